// >>> logic/iopf_params.svh
// Purpose: offsets, field positions, reset values and mode codes of the port I/O block
// Assumes: included by bare name from iopf_top only; the package and the pin select do not include it
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef IOPF_PARAMS_SVH
`define IOPF_PARAMS_SVH

// -----------------------------------------------------------------
// register offsets (low byte of haddr)
// -----------------------------------------------------------------
`define IOPF_OFS_P5_LATCH 8'h00
`define IOPF_OFS_P5_DIR 8'h04
`define IOPF_OFS_P5_PULLUP 8'h08
`define IOPF_OFS_PB_LATCH 8'h0c
`define IOPF_OFS_PB_DIR 8'h10
`define IOPF_OFS_FUNC_CTRL 8'h14
`define IOPF_OFS_PIN_STATUS 8'h18

// -----------------------------------------------------------------
// reset values and fixed bits
// -----------------------------------------------------------------
`define IOPF_P5_LATCH_RESET 8'hf0
`define IOPF_P5_PULLUP_RESET 8'hf0
`define IOPF_P5_FIXED_ONES 8'hf0
`define IOPF_PB_LATCH_RESET 8'h00
`define IOPF_DIR_RESET 8'h00
`define IOPF_FUNC_CTRL_RESET 8'h00

// -----------------------------------------------------------------
// function control fields
// -----------------------------------------------------------------
`define IOPF_FC_CHIPSEL_SIX_ENABLE 0
`define IOPF_FC_CHIPSEL_SEVEN_ENABLE 1
`define IOPF_FC_PAT9 2
`define IOPF_FC_PAT8 3
`define IOPF_FC_DMA_EXT 4

// -----------------------------------------------------------------
// operating modes with port 5 pull-ups available
// -----------------------------------------------------------------
`define IOPF_MODE_PULLUP_A 3'h5
`define IOPF_MODE_PULLUP_B 3'h7

`endif

// >>> logic/iopf_pin_sel.sv
// Purpose: function select for one multiplexed port B pin
// Assumes: all selects are stable register or timer levels
// Notes: purely combinational; the caller registers the pin drive
`timescale 1ns/1ps
`default_nettype none

module iopf_pin_sel
   import iopf_pkg::*;
(
   // selects
   input wire logic dma_force_in_i,
   input wire logic timer_sel_nz_i,
   input wire logic chipsel_en_i,
   input wire logic dir_i,
   input wire logic pattern_en_i,
   // candidate output values
   input wire logic latch_i,
   input wire logic pattern_val_i,
   input wire logic chipsel_val_i,
   input wire logic timer_val_i,
   // result
   output iopf_pin_fn_t fn_o,
   output logic out_o,
   output logic oe_o
);

   // priority: dma request, timer, chip select, then port/pattern
   always_comb begin
      fn_o = iopf_fn_port_in;
      out_o = 1'b0;
      oe_o = 1'b0;
      if (dma_force_in_i) begin
         fn_o = iopf_fn_dma_in;
      end else if (timer_sel_nz_i) begin
         fn_o = iopf_fn_timer;
         out_o = timer_val_i;
         oe_o = 1'b1;
      end else if (chipsel_en_i) begin
         fn_o = iopf_fn_chipsel;
         out_o = chipsel_val_i;
         oe_o = 1'b1;
      end else if (!dir_i) begin
         fn_o = iopf_fn_port_in;
      end else if (!pattern_en_i) begin
         fn_o = iopf_fn_port_out;
         out_o = latch_i;
         oe_o = 1'b1;
      end else begin
         fn_o = iopf_fn_pattern;
         out_o = pattern_val_i;
         oe_o = 1'b1;
      end
   end

endmodule
`default_nettype wire

// >>> logic/iopf_pkg.sv
// Purpose: types shared by the port I/O block
// Assumes: nothing, not even the params header
// Notes: pin function codes also show in the status register
package iopf_pkg;

   // -----------------------------------------------------------------
   // pin function of a multiplexed port B pin
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      iopf_fn_port_in,
      iopf_fn_port_out,
      iopf_fn_pattern,
      iopf_fn_chipsel,
      iopf_fn_timer,
      iopf_fn_dma_in
   } iopf_pin_fn_t;

endpackage

// >>> logic/iopf_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs may change at any time relative to clk_sys_i
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module iopf_sync #(
   parameter int WIDTH = 12
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // two flops so metastability settles before anyone looks
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule
`default_nettype wire

// >>> logic/iopf_top.sv
// Purpose: port 5 and port B I/O with pin function select, AHB-Lite register slave
// Assumes: one clock, synchronous reset; hardware standby resets the port registers and pin flops like rst_i
// Notes: software standby needs no logic, the registers simply hold
// Summary of operation
// - an output pin is driven from its bit of the port output latch.
// - a port read returns the latch bit where direction is 1 and the pin level where it is 0.
// - port 5 latch bits 7 to 4 read 1, cannot be written, and the latch resets to 0xf0.
// - port 5 latch, port 5 pull-up control and port B latch hold through software standby.
// - in modes 5 and 7 a port 5 pull-up is on only for direction 0 and pull-up bit 1.
// - port 5 pull-up control bits 7 to 4 are fixed at 1 and the register resets to 0xf0.
// - the port B latch is eight read/write bits that reset to 0x00.
// - pin B1 with no timer or chip select is input, port output or pattern output 9.
// - pin B1 is timer channel 1 output if any timer select is set, else chip select six if enabled.
// - pin B1 feeds the channel 1 timer input when both counter-clear bits are 1.
// - with external DMA requests selected, pin B1 is the DMA request input above all else.
// - pin B0 is timer channel 0 output, else chip select seven, else input, output or pattern 8.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "iopf_params.svh"

module iopf_top
   import iopf_pkg::*;
#(
   parameter int P5_PINS = 4,
   parameter int PB_PINS = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // power state and mode
   input wire logic hw_standby_i,
   input wire logic [2:0] mode_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // port 5 pins
   input wire logic [P5_PINS-1:0] port5_pin_i,
   output logic [P5_PINS-1:0] port5_pin_o,
   output logic [P5_PINS-1:0] port5_pin_oe_o,
   output logic [P5_PINS-1:0] port5_pullup_on_o,
   // port B pins
   input wire logic [PB_PINS-1:0] portb_pin_i,
   output logic [PB_PINS-1:0] portb_pin_o,
   output logic [PB_PINS-1:0] portb_pin_oe_o,
   // timer 8 channel 1 selects and signals
   input wire logic [1:0] timer8_output_level_select_hi_ch1_i,
   input wire logic [1:0] timer8_output_select_lo_ch1_i,
   input wire logic counter_clear_select_hi_i,
   input wire logic counter_clear_select_lo_i,
   input wire logic timer8_io_ch1_i,
   output logic timer8_io_ch1_o,
   // timer 8 channel 0 selects and output
   input wire logic [1:0] timer8_output_level_select_hi_ch0_i,
   input wire logic [1:0] timer8_output_select_lo_ch0_i,
   input wire logic timer8_output_ch0_i,
   // pattern, chip select and dma
   input wire logic pattern_output_nine_i,
   input wire logic pattern_output_eight_i,
   input wire logic chipsel_six_output_n_i,
   input wire logic chipsel_seven_output_n_i,
   output logic dma_request_input_zero_n_o
);

   // -----------------------------------------------------------------
   // registers and internal signals
   // -----------------------------------------------------------------
   logic clear_all;
   logic [7:0] port5_output_latch;
   logic [7:0] port5_direction_bits;
   logic [7:0] port5_pullup_control;
   logic [7:0] portb_output_latch;
   logic [7:0] portb_direction_bits;
   logic [7:0] func_ctrl;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [P5_PINS+PB_PINS-1:0] pins_sync;
   logic [7:0] port5_level;
   logic [7:0] portb_level;
   logic [7:0] port5_read;
   logic [7:0] portb_read;
   logic addr_phase;
   iopf_pin_fn_t pb0_fn;
   iopf_pin_fn_t pb1_fn;
   logic pb0_out;
   logic pb0_oe;
   logic pb1_out;
   logic pb1_oe;
   logic [PB_PINS-1:0] next_portb_out;
   logic [PB_PINS-1:0] next_portb_oe;
   logic pullup_mode;

   // hardware standby clears the port registers and pin outputs as reset does; bus and synchroniser flops follow rst_i only
   assign clear_all = rst_i | hw_standby_i;

   // -----------------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------------
   // zero wait states and always OKAY: every register is a plain flop
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign addr_phase = hsel_i & htrans_i[1] & hready_i;

   // read mux shared by address decode; unmapped offsets read zero
   function automatic logic [31:0] read_word(input logic [7:0] ofs, input logic [7:0] p5, input logic [7:0] pb);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (ofs)
         `IOPF_OFS_P5_LATCH: w = {24'h00_0000, p5};
         `IOPF_OFS_P5_DIR: w = {24'h00_0000, port5_direction_bits};
         `IOPF_OFS_P5_PULLUP: w = {24'h00_0000, port5_pullup_control};
         `IOPF_OFS_PB_LATCH: w = {24'h00_0000, pb};
         `IOPF_OFS_PB_DIR: w = {24'h00_0000, portb_direction_bits};
         `IOPF_OFS_FUNC_CTRL: w = {24'h00_0000, func_ctrl};
         `IOPF_OFS_PIN_STATUS: w = {24'h00_0000, 2'b00, pb1_fn, pb0_fn};
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // capture the address phase; the write lands at the end of the data phase
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase & hwrite_i;
         wr_addr <= haddr_i[7:0];
      end
   end

   // read data is fetched at the address edge so it stands through the data phase
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_phase & ~hwrite_i) begin
         hrdata_o <= read_word(haddr_i[7:0], port5_read, portb_read);
      end
   end

   // -----------------------------------------------------------------
   // port 5 registers
   // -----------------------------------------------------------------
   // no standby term: software standby simply leaves these alone
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         port5_output_latch <= `IOPF_P5_LATCH_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_P5_LATCH) begin
         port5_output_latch <= hwdata_i[7:0] | `IOPF_P5_FIXED_ONES;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         port5_pullup_control <= `IOPF_P5_PULLUP_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_P5_PULLUP) begin
         port5_pullup_control <= hwdata_i[7:0] | `IOPF_P5_FIXED_ONES;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         port5_direction_bits <= `IOPF_DIR_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_P5_DIR) begin
         port5_direction_bits <= hwdata_i[7:0];
      end
   end

   // -----------------------------------------------------------------
   // port B registers and function control
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         portb_output_latch <= `IOPF_PB_LATCH_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_PB_LATCH) begin
         portb_output_latch <= hwdata_i[7:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         portb_direction_bits <= `IOPF_DIR_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_PB_DIR) begin
         portb_direction_bits <= hwdata_i[7:0];
      end
   end

   // chip select, pattern and dma source enables; bits 7 to 5 read zero
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         func_ctrl <= `IOPF_FUNC_CTRL_RESET;
      end else if (wr_pend && wr_addr == `IOPF_OFS_FUNC_CTRL) begin
         func_ctrl <= {3'b000, hwdata_i[4:0]};
      end
   end

   // -----------------------------------------------------------------
   // pin input path
   // -----------------------------------------------------------------
   // pin levels only reach the read path after two flops
   iopf_sync #(
      .WIDTH(P5_PINS + PB_PINS)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({port5_pin_i, portb_pin_i}),
      .sync_o(pins_sync)
   );

   // missing port 5 pins read as the fixed-one latch bits
   always_comb begin
      port5_level = 8'hff;
      portb_level = 8'h00;
      port5_level[P5_PINS-1:0] = pins_sync[P5_PINS+PB_PINS-1:PB_PINS];
      portb_level[PB_PINS-1:0] = pins_sync[PB_PINS-1:0];
   end

   // latch bit where direction is 1, pin level where it is 0
   assign port5_read = (port5_output_latch & port5_direction_bits) |
                       (port5_level & ~port5_direction_bits);
   assign portb_read = (portb_output_latch & portb_direction_bits) |
                       (portb_level & ~portb_direction_bits);

   // -----------------------------------------------------------------
   // port B pin function select
   // -----------------------------------------------------------------
   iopf_pin_sel u_pb1 (
      .dma_force_in_i(func_ctrl[`IOPF_FC_DMA_EXT]),
      .timer_sel_nz_i(|{timer8_output_level_select_hi_ch1_i,
                        timer8_output_select_lo_ch1_i}),
      .chipsel_en_i(func_ctrl[`IOPF_FC_CHIPSEL_SIX_ENABLE]),
      .dir_i(portb_direction_bits[1]),
      .pattern_en_i(func_ctrl[`IOPF_FC_PAT9]),
      .latch_i(portb_output_latch[1]),
      .pattern_val_i(pattern_output_nine_i),
      .chipsel_val_i(chipsel_six_output_n_i),
      .timer_val_i(timer8_io_ch1_i),
      .fn_o(pb1_fn),
      .out_o(pb1_out),
      .oe_o(pb1_oe)
   );

   // pin B0 has no dma role
   iopf_pin_sel u_pb0 (
      .dma_force_in_i(1'b0),
      .timer_sel_nz_i(|{timer8_output_level_select_hi_ch0_i,
                        timer8_output_select_lo_ch0_i}),
      .chipsel_en_i(func_ctrl[`IOPF_FC_CHIPSEL_SEVEN_ENABLE]),
      .dir_i(portb_direction_bits[0]),
      .pattern_en_i(func_ctrl[`IOPF_FC_PAT8]),
      .latch_i(portb_output_latch[0]),
      .pattern_val_i(pattern_output_eight_i),
      .chipsel_val_i(chipsel_seven_output_n_i),
      .timer_val_i(timer8_output_ch0_i),
      .fn_o(pb0_fn),
      .out_o(pb0_out),
      .oe_o(pb0_oe)
   );

   // plain port bits above pin 1 follow latch and direction
   always_comb begin
      next_portb_out = portb_output_latch[PB_PINS-1:0];
      next_portb_oe = portb_direction_bits[PB_PINS-1:0];
      next_portb_out[1] = pb1_out;
      next_portb_oe[1] = pb1_oe;
      next_portb_out[0] = pb0_out;
      next_portb_oe[0] = pb0_oe;
   end

   // -----------------------------------------------------------------
   // pin drive flops
   // -----------------------------------------------------------------
   // registered so pins never glitch while selects settle; costs one cycle
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         portb_pin_o <= '0;
         portb_pin_oe_o <= '0;
      end else begin
         portb_pin_o <= next_portb_out;
         portb_pin_oe_o <= next_portb_oe;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         port5_pin_o <= '0;
         port5_pin_oe_o <= '0;
      end else begin
         port5_pin_o <= port5_output_latch[P5_PINS-1:0];
         port5_pin_oe_o <= port5_direction_bits[P5_PINS-1:0];
      end
   end

   // -----------------------------------------------------------------
   // pull-ups
   // -----------------------------------------------------------------
   assign pullup_mode = (mode_i == `IOPF_MODE_PULLUP_A) || (mode_i == `IOPF_MODE_PULLUP_B);

   // only inputs get pulled, and only in the modes that support it
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         port5_pullup_on_o <= '0;
      end else begin
         port5_pullup_on_o <= {P5_PINS{pullup_mode}} & ~port5_direction_bits[P5_PINS-1:0] &
                              port5_pullup_control[P5_PINS-1:0];
      end
   end

   // -----------------------------------------------------------------
   // timer and dma inputs from pin B1
   // -----------------------------------------------------------------
   // the timer sees the pin only when its clear source is the input edge
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         timer8_io_ch1_o <= 1'b0;
      end else begin
         timer8_io_ch1_o <= counter_clear_select_hi_i & counter_clear_select_lo_i &
                            pins_sync[1];
      end
   end

   // request is active low; idles high whenever the source is not selected
   always_ff @(posedge clk_sys_i) begin
      if (clear_all) begin
         dma_request_input_zero_n_o <= 1'b1;
      end else begin
         dma_request_input_zero_n_o <= ~func_ctrl[`IOPF_FC_DMA_EXT] | pins_sync[1];
      end
   end

endmodule
`default_nettype wire

// >>> tb/iopf_board_model.sv
// Purpose: board circuitry on the port 5 and port B pins
// Assumes: the board drives undriven pins unless a port 5 pin is set to float
// Notes: an unpulled floating pin shows the inverse of the last drive
`timescale 1ns/1ps
`default_nettype none

module iopf_board_model #(
   parameter int P5_PINS = 4,
   parameter int PB_PINS = 8
) (
   // device side of port 5
   input wire logic [P5_PINS-1:0] p5_drv_i,
   input wire logic [P5_PINS-1:0] p5_oe_i,
   input wire logic [P5_PINS-1:0] p5_pu_i,
   // board setting of port 5
   input wire logic [P5_PINS-1:0] p5_board_i,
   input wire logic [P5_PINS-1:0] p5_float_i,
   // device side and board setting of port B
   input wire logic [PB_PINS-1:0] pb_drv_i,
   input wire logic [PB_PINS-1:0] pb_oe_i,
   input wire logic [PB_PINS-1:0] pb_board_i,
   // resolved wire levels
   output logic [P5_PINS-1:0] p5_pin_o,
   output logic [PB_PINS-1:0] pb_pin_o
);
   // device drive wins; a floating line rests on its pull-up if on
   assign p5_pin_o = (p5_oe_i & p5_drv_i) | (~p5_oe_i & p5_float_i & (p5_pu_i | ~p5_drv_i))
      | (~p5_oe_i & ~p5_float_i & p5_board_i);
   assign pb_pin_o = (pb_oe_i & pb_drv_i) | (~pb_oe_i & pb_board_i);
endmodule
`default_nettype wire

// >>> tb/iopf_checker_assertions.sv
// Purpose: port-level checks of the port I/O block
// Assumes: bound to iopf_top; pin outputs register one edge after their inputs
// Notes: register contents are unseen here, the bench reads them back
`timescale 1ns/1ps
`default_nettype none

module iopf_checker #(
   parameter int P5_PINS = 4,
   parameter int PB_PINS = 8
) (
   // clock, reset and mode
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic hw_standby_i,
   input wire logic [2:0] mode_i,
   // bus answer
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // pins
   input wire logic [P5_PINS-1:0] port5_pin_oe_o,
   input wire logic [P5_PINS-1:0] port5_pullup_on_o,
   input wire logic [PB_PINS-1:0] portb_pin_i,
   input wire logic [PB_PINS-1:0] portb_pin_o,
   input wire logic [PB_PINS-1:0] portb_pin_oe_o,
   // timer and dma
   input wire logic [1:0] timer8_output_level_select_hi_ch1_i,
   input wire logic [1:0] timer8_output_select_lo_ch1_i,
   input wire logic [1:0] timer8_output_level_select_hi_ch0_i,
   input wire logic [1:0] timer8_output_select_lo_ch0_i,
   input wire logic counter_clear_select_hi_i,
   input wire logic counter_clear_select_lo_i,
   input wire logic timer8_io_ch1_i,
   input wire logic timer8_io_ch1_o,
   input wire logic timer8_output_ch0_i,
   input wire logic dma_request_input_zero_n_o
);
   // ------
   // folded selects
   // ------
   wire logic nz1 = |{timer8_output_level_select_hi_ch1_i, timer8_output_select_lo_ch1_i};
   wire logic nz0 = |{timer8_output_level_select_hi_ch0_i, timer8_output_select_lo_ch0_i};
   wire logic cc = counter_clear_select_hi_i & counter_clear_select_lo_i;
   // pb0 timer case skips cycles held in reset or standby
   wire logic t0 = nz0 & ~hw_standby_i & ~rst_i;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not okay");
   a_pull_in_only: assert property ((port5_pullup_on_o & port5_pin_oe_o) == '0)
      else $error("pull-up on driven pin");
   a_pull_mode: assert property (|port5_pullup_on_o |-> $past(mode_i) inside {3'h5, 3'h7})
      else $error("pull-up outside modes 5, 7");
   a_pb0_timer: assert property ($past(t0) |->
      portb_pin_oe_o[0] && portb_pin_o[0] == $past(timer8_output_ch0_i))
      else $error("pb0 not timer output");
   a_pb1_timer: assert property ($past(nz1) && portb_pin_oe_o[1] |->
      portb_pin_o[1] == $past(timer8_io_ch1_i))
      else $error("pb1 not timer output");
   a_dma_pin: assert property (!dma_request_input_zero_n_o |->
      !portb_pin_oe_o[1] && !$past(portb_pin_i[1], 3))
      else $error("dma request not from pb1");
   a_tmr_in_gate: assert property (timer8_io_ch1_o |-> $past(cc) && $past(portb_pin_i[1], 3))
      else $error("timer input ungated");
   a_standby_clear: assert property ($past(hw_standby_i) |-> portb_pin_oe_o == '0 &&
      port5_pin_oe_o == '0 && port5_pullup_on_o == '0 && dma_request_input_zero_n_o && !timer8_io_ch1_o)
      else $error("standby left outputs set");

   c_dma_low: cover property (!dma_request_input_zero_n_o);
   c_tmr_in: cover property (timer8_io_ch1_o);
   c_pullup: cover property (|port5_pullup_on_o);
endmodule

bind iopf_top iopf_checker #(.P5_PINS(P5_PINS), .PB_PINS(PB_PINS)) u_chk (
   .clk_sys_i, .rst_i, .hw_standby_i, .mode_i, .hreadyout_o, .hresp_o,
   .port5_pin_oe_o, .port5_pullup_on_o, .portb_pin_i, .portb_pin_o, .portb_pin_oe_o,
   .timer8_output_level_select_hi_ch1_i, .timer8_output_select_lo_ch1_i,
   .timer8_output_level_select_hi_ch0_i, .timer8_output_select_lo_ch0_i,
   .counter_clear_select_hi_i, .counter_clear_select_lo_i, .timer8_io_ch1_i,
   .timer8_io_ch1_o, .timer8_output_ch0_i, .dma_request_input_zero_n_o
);
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: directed bench for the port I/O block
// Assumes: board model on the pins
// Notes: transfers are one idle cycle apart
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module tb_top;
   // ------
   // stimulus and observed signals
   // ------
   logic clk_sys_i = 0, rst_i = 1, hw_sb = 0, hwrite = 0, hready, hresp, tio, dma_n;
   logic [2:0] mode = 0;
   logic [1:0] htrans = 0, h1 = 0, l1 = 0, h0 = 0, l0 = 0, cc = 0, e1, e0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
   logic [5:0] src = 0;
   logic [3:0] board5 = 4'h5, float5 = 0, p5_in, p5_o, p5_oe, p5_pu;
   logic [7:0] boardb = 8'h3c, pb_in, pb_o, pb_oe;
   int failures = 0, n_checks = 0, cyc = 0;
   // pin table: control, direction, timer select, status
   localparam logic [4:0] FC [8] = '{5'h00, 5'h00, 5'h0c, 5'h0c, 5'h03, 5'h0f, 5'h0f, 5'h1f};
   localparam logic [7:0] DR = 8'hea;
   localparam logic [7:0] NZ = 8'hc0;
   localparam logic [5:0] ST [8] = '{6'h00, 6'h09, 6'h00, 6'h12, 6'h1b, 6'h1b, 6'h24, 6'h2c};

   always #50 clk_sys_i = ~clk_sys_i;

   iopf_top dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hw_standby_i(hw_sb), .mode_i(mode),
      .hsel_i(htrans[1]), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .port5_pin_i(p5_in), .port5_pin_o(p5_o), .port5_pin_oe_o(p5_oe), .port5_pullup_on_o(p5_pu),
      .portb_pin_i(pb_in), .portb_pin_o(pb_o), .portb_pin_oe_o(pb_oe),
      .timer8_output_level_select_hi_ch1_i(h1), .timer8_output_select_lo_ch1_i(l1),
      .counter_clear_select_hi_i(cc[1]), .counter_clear_select_lo_i(cc[0]),
      .timer8_io_ch1_i(src[1]), .timer8_io_ch1_o(tio),
      .timer8_output_level_select_hi_ch0_i(h0), .timer8_output_select_lo_ch0_i(l0),
      .timer8_output_ch0_i(src[0]), .pattern_output_nine_i(src[5]), .pattern_output_eight_i(src[4]),
      .chipsel_six_output_n_i(src[3]), .chipsel_seven_output_n_i(src[2]),
      .dma_request_input_zero_n_o(dma_n)
   );

   iopf_board_model u_board (
      .p5_drv_i(p5_o), .p5_oe_i(p5_oe), .p5_pu_i(p5_pu), .p5_board_i(board5), .p5_float_i(float5),
      .pb_drv_i(pb_o), .pb_oe_i(pb_oe), .pb_board_i(boardb), .p5_pin_o(p5_in), .pb_pin_o(pb_in)
   );

   // ------
   // bus cycles and helpers
   // ------
   // address phase, then data phase, each held until ready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys_i);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `CHK(rdv, e)
   endtask
   // covers a write, the pin synchroniser and the pin flops
   task automatic settle;
      repeat (6) @(posedge clk_sys_i);
      #1;
   endtask
   // expected {drive enable, value} of a pin from its function code
   function automatic logic [1:0] pinv(input logic [2:0] c, input logic [3:0] v);
      pinv = (c inside {[3'h1:3'h4]}) ? {1'b1, v[c - 3'h1]} : 2'b00;
   endfunction
   task automatic conclude;
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         failures++;
         conclude;
      end
   end

   // ------
   // main sequence
   // ------
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle;
      rd(8'h00, 32'hf5);
      rd(8'h08, 32'hf0);
      rd(8'h0c, 32'h3c);
      wr(8'h10, 32'hff);
      rd(8'h0c, 32'h00);
      wr(8'h0c, 32'ha5);
      wr(8'h10, 32'hf0);
      settle;
      rd(8'h0c, 32'hac);
      wr(8'h00, 32'h09);
      wr(8'h04, 32'h0c);
      rd(8'h00, 32'hf9);
      settle;
      `CHK({pb_o[7:4], p5_o[3:2]}, 6'h2a)
      `CHK({pb_oe, p5_oe}, 12'hf0c)
      wr(8'h08, 32'h07);
      rd(8'h08, 32'hf7);
      float5 <= 4'hf;
      for (int m = 0; m < 8; m++) begin
         @(posedge clk_sys_i);
         mode <= m[2:0];
         settle;
         `CHK(p5_pu, (m == 5 || m == 7) ? 4'h3 : 4'h0)
      end
      rd(8'h00, 32'hfb);
      @(posedge clk_sys_i);
      float5 <= 4'h0;
      hw_sb <= 1'b1;
      @(posedge clk_sys_i);
      hw_sb <= 1'b0;
      settle;
      rd(8'h00, 32'hf5);
      rd(8'h08, 32'hf0);
      rd(8'h04, 32'h00);
      wr(8'h10, 32'hff);
      rd(8'h0c, 32'h00);
      wr(8'h1c, 32'hffff_ffff);
      rd(8'h1c, 32'h0);
      // every pin function, two passes with opposite source values
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_sys_i);
         src <= p[0] ? 6'b010110 : 6'b101001;
         boardb <= {6'h0, ~p[0], p[0]};
         cc <= p[0] ? 2'b11 : 2'b10;
         wr(8'h0c, {30'h0, p[0], ~p[0]});
         for (int i = 0; i < 8; i++) begin
            h1 <= p[0] ? 2'b00 : {NZ[i], 1'b0};
            l1 <= p[0] ? {1'b0, NZ[i]} : 2'b00;
            h0 <= p[0] ? {NZ[i], NZ[i]} : 2'b00;
            l0 <= p[0] ? 2'b00 : {NZ[i], 1'b0};
            wr(8'h14, {27'h0, FC[i]});
            wr(8'h10, {30'h0, {2{DR[i]}}});
            settle;
            rd(8'h18, {26'h0, ST[i]});
            #1;
            e1 = pinv(ST[i][5:3], {src[1], src[3], src[5], p[0]});
            e0 = pinv(ST[i][2:0], {src[0], src[2], src[4], ~p[0]});
            `CHK(pb_oe[1:0], {e1[1], e0[1]})
            `CHK(pb_o[1:0] & pb_oe[1:0], {e1[1] & e1[0], e0[1] & e0[0]})
            `CHK(dma_n, FC[i][4] ? ~p[0] : 1'b1)
            `CHK(tio, p[0] ? (e1[1] ? e1[0] : ~p[0]) : 1'b0)
            @(posedge clk_sys_i);
         end
      end
      conclude;
   end
endmodule
`default_nettype wire
